// *** dual_input_param_scaling.sv ***
`timescale 1ns/1ps
module dual_input_param_scaling
  import scaling_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // parameter byte port, one byte per object index
  input wire logic prm_wr,
  input wire logic prm_rd,
  input wire logic [3:0] prm_index,
  input wire logic [7:0] prm_wdata,
  output logic [7:0] prm_rdata,
  input wire logic stop_state,
  // conversion results in millivolts
  input wire logic signed [15:0] ch0_mv,
  input wire logic signed [15:0] ch1_mv,
  input wire logic conv_done,
  // scaled values
  output logic signed [15:0] ch0_value,
  output logic signed [15:0] ch1_value,
  output logic [1:0] value_valid,
  // events and status
  output logic [1:0] limit_over,
  output logic [1:0] limit_under,
  output logic proc_irq,
  output logic interrupt_report_enable_irq,
  output logic param_err,
  output logic [MAINS_W-1:0] mains_sel
);
  // ----------------------------------------
  // parameter store
  // ----------------------------------------
  logic [7:0] irq_en_r, irq_en_nxt;
  logic [LIM_EN_W-1:0] lim_en_r, lim_en_nxt;
  logic [MAINS_W-1:0] mains_r, mains_nxt;
  logic [7:0] code_r [2];
  logic [7:0] code_nxt [2];
  logic [15:0] hi_r [2];
  logic [15:0] hi_nxt [2];
  logic [15:0] lo_r [2];
  logic [15:0] lo_nxt [2];
  logic [7:0] stage_r, stage_nxt;
  logic perr_r, perr_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic accept, refuse;

  // a bound is legal inside the nominal span or as an off value
  function automatic logic bound_ok(input logic [7:0] code, input logic [15:0] w);
    logic signed [15:0] nom;
    nom = (code == CODE_FMT_B) ? B_NOM : A_NOM;
    return w == RST_HI || w == RST_LO || ($signed(w) >= 0 && $signed(w) <= nom);
  endfunction : bound_ok

  function automatic logic code_ok(input logic [7:0] c);
    return c == CODE_FMT_A || c == CODE_FMT_B || c == CODE_OFF;
  endfunction : code_ok

  // record that carries a byte index; only the general one is gated by stop
  function automatic logic [7:0] record_of(input logic [3:0] idx);
    if (idx < IDX_MAINS) return REC_GENERAL;
    if (idx == IDX_MAINS) return REC_MAINS;
    return (idx < IDX_CODE[1]) ? REC_CH0 : REC_CH1;
  endfunction : record_of

  // slot subindex of a byte index; both bytes of a bound share one entry
  function automatic logic [7:0] subidx_of(input logic [3:0] idx);
    logic [7:0] i;
    i = {4'h0, idx};
    if (idx < IDX_HI[0]) return i + SUBIDX_FIRST;
    if (idx < IDX_CODE[1]) return 8'h07 + ((i - 8'h06) >> 1);
    if (idx < IDX_HI[1]) return i - 8'h01;
    return 8'h0B + ((i - 8'h0C) >> 1);
  endfunction : subidx_of

  // write decode: word bounds go high byte first, low byte commits
  always_comb begin
    irq_en_nxt = irq_en_r;
    lim_en_nxt = lim_en_r;
    mains_nxt = mains_r;
    code_nxt = code_r;
    hi_nxt = hi_r;
    lo_nxt = lo_r;
    stage_nxt = stage_r;
    perr_nxt = perr_r;
    accept = 1'b0;
    refuse = 1'b0;
    if (prm_wr) begin
      case (prm_index)
        IDX_IRQ_EN: begin
          // general record only taken while stopped
          if (stop_state) irq_en_nxt = prm_wdata;
          accept = stop_state;
          refuse = !stop_state;
        end
        IDX_LIM_EN: begin
          if (stop_state) lim_en_nxt = prm_wdata[LIM_EN_W-1:0];
          accept = stop_state;
          refuse = !stop_state;
        end
        IDX_MAINS: begin
          mains_nxt = prm_wdata[MAINS_W-1:0];
          accept = 1'b1;
        end
        default: ; // spare bytes drop writes
      endcase
      for (int c = 0; c < 2; c++) begin
        if (prm_index == IDX_CODE[c]) begin
          if (code_ok(prm_wdata)) begin
            code_nxt[c] = prm_wdata;
            accept = 1'b1;
          end else begin
            refuse = 1'b1;
          end
        end
        if (prm_index == IDX_HI[c] || prm_index == IDX_LO[c]) begin
          stage_nxt = prm_wdata;
        end
        if (prm_index == (IDX_HI[c] | IDX_LOW_BYTE)) begin
          if (bound_ok(code_r[c], {stage_r, prm_wdata})) begin
            hi_nxt[c] = {stage_r, prm_wdata};
            accept = 1'b1;
          end else begin
            refuse = 1'b1;
          end
        end
        if (prm_index == (IDX_LO[c] | IDX_LOW_BYTE)) begin
          if (bound_ok(code_r[c], {stage_r, prm_wdata})) begin
            lo_nxt[c] = {stage_r, prm_wdata};
            accept = 1'b1;
          end else begin
            refuse = 1'b1;
          end
        end
      end
    end
    // a refusal in the same cycle wins over the clear
    if (accept) perr_nxt = 1'b0;
    if (refuse) perr_nxt = 1'b1;
  end

  // read decode: reserved bytes and bits read zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (prm_rd) begin
      case (prm_index)
        IDX_IRQ_EN: rdata_nxt = irq_en_r;
        IDX_LIM_EN: rdata_nxt = {6'h00, lim_en_r};
        IDX_MAINS: rdata_nxt = {4'h0, mains_r};
        IDX_CODE[0]: rdata_nxt = code_r[0];
        IDX_HI[0]: rdata_nxt = hi_r[0][15:8];
        IDX_HI[0] | IDX_LOW_BYTE: rdata_nxt = hi_r[0][7:0];
        IDX_LO[0]: rdata_nxt = lo_r[0][15:8];
        IDX_LO[0] | IDX_LOW_BYTE: rdata_nxt = lo_r[0][7:0];
        IDX_CODE[1]: rdata_nxt = code_r[1];
        IDX_HI[1]: rdata_nxt = hi_r[1][15:8];
        IDX_HI[1] | IDX_LOW_BYTE: rdata_nxt = hi_r[1][7:0];
        IDX_LO[1]: rdata_nxt = lo_r[1][15:8];
        IDX_LO[1] | IDX_LOW_BYTE: rdata_nxt = lo_r[1][7:0];
        default: rdata_nxt = RST_BYTE;
      endcase
    end
  end

  // defaults after reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_r <= IRQ_OFF;
      lim_en_r <= '0;
      mains_r <= '0;
      code_r <= '{RST_CODE, RST_CODE};
      hi_r <= '{RST_HI, RST_HI};
      lo_r <= '{RST_LO, RST_LO};
      stage_r <= RST_BYTE;
      perr_r <= 1'b0;
      rdata_r <= RST_BYTE;
    end else begin
      irq_en_r <= irq_en_nxt;
      lim_en_r <= lim_en_nxt;
      mains_r <= mains_nxt;
      code_r <= code_nxt;
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
      stage_r <= stage_nxt;
      perr_r <= perr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // channels
  // ----------------------------------------
  chan_if ch0 ();
  chan_if ch1 ();
  logic signed [15:0] val [2];
  logic [1:0] vvalid, ovr, und, lo_hit, hi_hit;

  assign ch0.code = code_r[0];
  assign ch0.mv = ch0_mv;
  assign ch0.mv_valid = conv_done;
  assign ch1.code = code_r[1];
  assign ch1.mv = ch1_mv;
  assign ch1.mv_valid = conv_done;
  assign val[0] = ch0.value;
  assign val[1] = ch1.value;
  assign vvalid = {ch1.value_valid, ch0.value_valid};
  assign ovr = {ch1.over_rng, ch0.over_rng};
  assign und = {ch1.under_rng, ch0.under_rng};

  value_scaler u_scale0 (.sys_clk(sys_clk), .rst_n(rst_n), .ch(ch0));
  value_scaler u_scale1 (.sys_clk(sys_clk), .rst_n(rst_n), .ch(ch1));

  // both watchers share one module, one per channel
  for (genvar c = 0; c < 2; c++) begin : g_watch
    limit_watch u_watch (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .value(val[c]),
      .valid(vvalid[c]),
      .enable(lim_en_r[c]),
      .hi(hi_r[c]),
      .lo(lo_r[c]),
      .over(hi_hit[c]),
      .under(lo_hit[c])
    );
  end

  // ----------------------------------------
  // events
  // ----------------------------------------
  logic proc_r, proc_nxt, interrupt_report_enable_r, interrupt_report_enable_nxt;
  logic [1:0] fault_r, fault_nxt;

  // range fault stands until a clean sample or an off code; interrupt_report_enable follows it or param_err
  always_comb begin
    fault_nxt = fault_r;
    for (int c = 0; c < 2; c++) begin
      if (vvalid[c]) fault_nxt[c] = ovr[c] | und[c];
      if (code_r[c] == CODE_OFF) fault_nxt[c] = 1'b0;
    end
    proc_nxt = |{hi_hit, lo_hit};
    interrupt_report_enable_nxt = (irq_en_r == IRQ_ON) && (perr_r || |fault_r);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_r <= '0;
      proc_r <= 1'b0;
      interrupt_report_enable_r <= 1'b0;
    end else begin
      fault_r <= fault_nxt;
      proc_r <= proc_nxt;
      interrupt_report_enable_r <= interrupt_report_enable_nxt;
    end
  end

  assign prm_rdata = rdata_r;
  assign ch0_value = val[0];
  assign ch1_value = val[1];
  assign value_valid = vvalid;
  assign limit_over = hi_hit;
  assign limit_under = lo_hit;
  assign proc_irq = proc_r;
  assign interrupt_report_enable_irq = interrupt_report_enable_r;
  assign param_err = perr_r;
  assign mains_sel = mains_r;

  a_code_refuse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    prm_wr && prm_index == IDX_CODE[0] && !code_ok(prm_wdata)
    |=> code_r[0] == $past(code_r[0]) && perr_r)
    else $error("bad range code was taken");
  a_irq_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    interrupt_report_enable_r |-> $past(irq_en_r) == IRQ_ON)
    else $error("interrupt_report_enable interrupt while not enabled");
  a_spare_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    prm_rd && (prm_index == IDX_SPARE_A || prm_index == (IDX_CODE[0] | IDX_LOW_BYTE))
    |=> rdata_r == RST_BYTE)
    else $error("spare byte read nonzero");
  a_off_silent: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_done && code_r[1] == CODE_OFF |=> !vvalid[1] ##1 !hi_hit[1] && !lo_hit[1])
    else $error("off channel measured");
  a_bound_refuse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    prm_wr && prm_index == (IDX_HI[0] | IDX_LOW_BYTE) && !bound_ok(code_r[0], {stage_r, prm_wdata})
    |=> hi_r[0] == $past(hi_r[0]) && perr_r)
    else $error("out of span bound taken");
  a_stop_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
    prm_wr && prm_index == IDX_LIM_EN && !stop_state |=> $stable(lim_en_r))
    else $error("limit enable changed while running");
  a_general_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    prm_wr && record_of(prm_index) == REC_GENERAL && !stop_state
    |=> $stable(irq_en_r) && $stable(lim_en_r))
    else $error("general record taken while running");
  a_subidx_span: assert property (@(posedge sys_clk) disable iff (!rst_n)
    prm_wr |-> subidx_of(prm_index) >= SUBIDX_FIRST && subidx_of(prm_index) <= SUBIDX_LAST)
    else $error("byte index outside the slot subindex span");
endmodule : dual_input_param_scaling

// *** scaling_pkg.sv ***
package scaling_pkg;
  // ----------------------------------------
  // parameter byte indices (object index low nibble)
  // ----------------------------------------
  localparam logic [15:0] OBJ_INDEX_BASE = 16'h3100;
  localparam logic [3:0] IDX_IRQ_EN = 4'h0;
  localparam logic [3:0] IDX_SPARE_A = 4'h1;
  localparam logic [3:0] IDX_LIM_EN = 4'h2;
  localparam logic [3:0] IDX_MAINS = 4'h3;
  localparam logic [3:0] IDX_CODE [2] = '{4'h4, 4'hA};
  localparam logic [3:0] IDX_HI [2] = '{4'h6, 4'hC};
  localparam logic [3:0] IDX_LO [2] = '{4'h8, 4'hE};
  localparam logic [3:0] IDX_LOW_BYTE = 4'h1;
  // record numbers and slot subindex span
  localparam logic [7:0] REC_GENERAL = 8'h00;
  localparam logic [7:0] REC_MAINS = 8'h01;
  localparam logic [7:0] REC_CH0 = 8'h80;
  localparam logic [7:0] REC_CH1 = 8'h81;
  localparam logic [7:0] SUBIDX_FIRST = 8'h01;
  localparam logic [7:0] SUBIDX_LAST = 8'h0C;
  // ----------------------------------------
  // codes, field positions, reset values
  // ----------------------------------------
  localparam logic [7:0] IRQ_OFF = 8'h00;
  localparam logic [7:0] IRQ_ON = 8'h40;
  localparam logic [7:0] CODE_FMT_A = 8'h10;
  localparam logic [7:0] CODE_FMT_B = 8'h20;
  localparam logic [7:0] CODE_OFF = 8'hFF;
  localparam int LIM_EN_W = 2;
  localparam int MAINS_W = 4;
  localparam logic [1:0] MAINS_NONE = 2'h0;
  localparam logic [1:0] MAINS_60HZ = 2'h1;
  localparam logic [1:0] MAINS_50HZ = 2'h2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_CODE = 8'h10;
  localparam logic [15:0] RST_HI = 16'h7FFF;
  localparam logic [15:0] RST_LO = 16'h8000;
  // ----------------------------------------
  // scaling: value = (mv * gain + half) >>> shift
  // ----------------------------------------
  localparam logic signed [15:0] FULL_MV = 16'sh2710;
  localparam logic signed [15:0] A_NOM = 16'sh6C00;
  localparam logic signed [15:0] A_MAX = 16'sh7EFF;
  localparam logic signed [15:0] A_MIN = -16'sh1300;
  localparam logic signed [15:0] B_NOM = 16'sh4000;
  localparam logic signed [15:0] B_MAX = 16'sh5000;
  localparam logic signed [15:0] B_MIN = -16'sh0CCD;
  localparam logic [23:0] A_GAIN = 24'h02C3C9;
  localparam logic [23:0] B_GAIN = 24'h01A36E;
  localparam int GAIN_SHIFT = 16;
  localparam logic signed [40:0] GAIN_HALF = 41'sh0_0000_8000;
endpackage : scaling_pkg

// *** chan_if.sv ***
`timescale 1ns/1ps
// one converter channel between control and scaler
interface chan_if;
  logic [7:0] code;
  logic signed [15:0] mv;
  logic mv_valid;
  logic signed [15:0] value;
  logic value_valid;
  logic over_rng;
  logic under_rng;
  modport scaler (input code, mv, mv_valid, output value, value_valid, over_rng, under_rng);
  modport ctrl (output code, mv, mv_valid, input value, value_valid, over_rng, under_rng);
endinterface : chan_if

// *** value_scaler.sv ***
`timescale 1ns/1ps
module value_scaler
  import scaling_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // channel
  chan_if.scaler ch
);
  logic signed [15:0] value_r, value_nxt;
  logic valid_r, valid_nxt, over_r, over_nxt, under_r, under_nxt;

  // rounded fixed-point gain, avoids a divider
  function automatic logic signed [40:0] scale(input logic signed [15:0] mv,
                                               input logic [23:0] gain);
    logic signed [40:0] p;
    p = 41'(mv) * $signed({1'b0, gain});
    return (p + GAIN_HALF) >>> GAIN_SHIFT;
  endfunction : scale

  // compute next sample; an off channel is never measured
  always_comb begin
    logic signed [40:0] s;
    logic signed [15:0] lo;
    logic signed [15:0] hi;
    s = '0;
    lo = A_MIN;
    hi = A_MAX;
    value_nxt = value_r;
    valid_nxt = 1'b0;
    over_nxt = over_r;
    under_nxt = under_r;
    if (ch.code == CODE_FMT_B) begin
      s = scale(ch.mv, B_GAIN);
      lo = B_MIN;
      hi = B_MAX;
    end else begin
      s = scale(ch.mv, A_GAIN);
    end
    if (ch.mv_valid && ch.code != CODE_OFF) begin
      valid_nxt = 1'b1;
      over_nxt = s > 41'(hi);
      under_nxt = s < 41'(lo);
      if (s > 41'(hi)) value_nxt = hi;
      else if (s < 41'(lo)) value_nxt = lo;
      else value_nxt = s[15:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      value_r <= '0;
      valid_r <= 1'b0;
      over_r <= 1'b0;
      under_r <= 1'b0;
    end else begin
      value_r <= value_nxt;
      valid_r <= valid_nxt;
      over_r <= over_nxt;
      under_r <= under_nxt;
    end
  end

  assign ch.value = value_r;
  assign ch.value_valid = valid_r;
  assign ch.over_rng = over_r;
  assign ch.under_rng = under_r;

  a_fmt_a_full: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ch.mv_valid && ch.code == CODE_FMT_A && ch.mv == FULL_MV |=> value_r == A_NOM)
    else $error("format A full scale wrong");
  a_fmt_b_span: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ch.mv_valid && ch.code == CODE_FMT_B |=> value_r <= B_MAX && value_r >= B_MIN)
    else $error("format B value out of span");
endmodule : value_scaler

// *** limit_watch.sv ***
`timescale 1ns/1ps
module limit_watch
  import scaling_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // sample and settings
  input wire logic signed [15:0] value,
  input wire logic valid,
  input wire logic enable,
  input wire logic [15:0] hi,
  input wire logic [15:0] lo,
  // one-cycle events
  output logic over,
  output logic under
);
  logic over_r, over_nxt, under_r, under_nxt;

  // bound values 7FFF/8000 switch that side off
  always_comb begin
    over_nxt = valid && enable && hi != RST_HI && value > $signed(hi);
    under_nxt = valid && enable && lo != RST_LO && value < $signed(lo);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      over_r <= 1'b0;
      under_r <= 1'b0;
    end else begin
      over_r <= over_nxt;
      under_r <= under_nxt;
    end
  end

  assign over = over_r;
  assign under = under_r;

  a_over_event: assert property (@(posedge sys_clk) disable iff (!rst_n)
    valid && enable && hi != RST_HI && value > $signed(hi) |=> over_r)
    else $error("upper limit crossing missed");
  a_bound_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    lo == RST_LO |=> !under_r)
    else $error("lower check not disabled");
endmodule : limit_watch

// *** coupler_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// backplane coupler model, master of the parameter port
// ----------------------------------------
module coupler_model (
  // clock
  input wire logic sys_clk,
  // parameter port toward the module
  output logic prm_wr,
  output logic prm_rd,
  output logic [3:0] prm_index,
  output logic [7:0] prm_wdata,
  output logic stop_state,
  input wire logic [7:0] prm_rdata
);
  // idle port at time zero, system running
  initial begin
    prm_wr = 1'b0;
    prm_rd = 1'b0;
    prm_index = 4'h0;
    prm_wdata = 8'h00;
    stop_state = 1'b0;
  end

  // one byte per object index, strobe high for one edge
  task automatic wr(input logic [3:0] idx, input logic [7:0] data);
    @(posedge sys_clk);
    prm_wr <= 1'b1;
    prm_index <= idx;
    prm_wdata <= data;
    @(posedge sys_clk);
    prm_wr <= 1'b0;
    prm_wdata <= ~data; // released data must not keep showing the old byte
  endtask : wr

  // this task sends a general record byte while the system is stopped; plain wr sends it while running
  task automatic wr_general(input logic [3:0] idx, input logic [7:0] data);
    @(posedge sys_clk);
    stop_state <= 1'b1;
    wr(idx, data);
    @(posedge sys_clk);
    stop_state <= 1'b0;
  endtask : wr_general

  // read byte is taken at the falling edge after the strobe edge
  task automatic rd(input logic [3:0] idx, output logic [7:0] data);
    @(posedge sys_clk);
    prm_rd <= 1'b1;
    prm_index <= idx;
    @(posedge sys_clk);
    prm_rd <= 1'b0;
    @(negedge sys_clk);
    data = prm_rdata;
  endtask : rd
endmodule : coupler_model

// *** dual_input_param_scaling_tb.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// testbench for the parameter and scaling block
// ----------------------------------------
module dual_input_param_scaling_tb
  import scaling_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic prm_wr, prm_rd, stop_state;
  logic [3:0] prm_index;
  logic [7:0] prm_wdata, prm_rdata;
  logic signed [15:0] ch0_mv = 16'h0000;
  logic signed [15:0] ch1_mv = 16'h0000;
  logic conv_done = 1'b0;
  logic signed [15:0] ch0_value, ch1_value;
  logic [1:0] value_valid, limit_over, limit_under;
  logic proc_irq, interrupt_report_enable_irq, param_err;
  logic [MAINS_W-1:0] mains_sel;
  int fail_count = 0;
  int checked = 0;
  // reset image of the sixteen parameter bytes
  logic [7:0] rst_tab [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h7F, 8'hFF,
                               8'h80, 8'h00, 8'h10, 8'h00, 8'h7F, 8'hFF, 8'h80, 8'h00};
  // inputs 13000, -3000, 10000, 5000, 0 mV; last one in range to clear faults
  logic signed [15:0] mv_tab [5] = '{16'h32C8, 16'hF448, 16'h2710, 16'h1388, 16'h0000};
  logic signed [15:0] a_tab [5] = '{16'h7EFF, 16'hED00, 16'h6C00, 16'h3600, 16'h0000};
  logic signed [15:0] b_tab [5] = '{16'h5000, 16'hF333, 16'h4000, 16'h2000, 16'h0000};

  // 20 MHz clock
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  dual_input_param_scaling dual_input_param_scaling_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .prm_wr(prm_wr), .prm_rd(prm_rd),
    .prm_index(prm_index), .prm_wdata(prm_wdata), .prm_rdata(prm_rdata),
    .stop_state(stop_state), .ch0_mv(ch0_mv), .ch1_mv(ch1_mv), .conv_done(conv_done),
    .ch0_value(ch0_value), .ch1_value(ch1_value), .value_valid(value_valid),
    .limit_over(limit_over), .limit_under(limit_under), .proc_irq(proc_irq),
    .interrupt_report_enable_irq(interrupt_report_enable_irq), .param_err(param_err), .mains_sel(mains_sel)
  );

  coupler_model coupler_model_inst (
    .sys_clk(sys_clk), .prm_wr(prm_wr), .prm_rd(prm_rd), .prm_index(prm_index),
    .prm_wdata(prm_wdata), .stop_state(stop_state), .prm_rdata(prm_rdata)
  );

  // ----------------------------------------
  // shared checks and transfers
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
      fail_count++;
    end
  endtask : check

  task automatic rd_check(input logic [3:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    coupler_model_inst.rd(idx, d);
    check({8'h00, d}, {8'h00, exp}, "parameter byte");
  endtask : rd_check

  // both samples offered on one strobe; results settle one edge later
  task automatic conv(input logic signed [15:0] m0, input logic signed [15:0] m1);
    @(posedge sys_clk);
    ch0_mv <= m0;
    ch1_mv <= m1;
    conv_done <= 1'b1;
    @(posedge sys_clk);
    conv_done <= 1'b0;
    ch0_mv <= ~m0;
    ch1_mv <= ~m1;
    @(negedge sys_clk);
  endtask : conv

  task automatic end_of_test();
    $display("checked %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // watchdog: the tests need well under a thousand cycles
  initial begin
    #1000000;
    fail_count++;
    end_of_test();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset image of every byte index
    for (int i = 0; i < 16; i++) begin
      rd_check(i[3:0], rst_tab[i]);
    end
    check({15'h0, param_err}, 16'h0000, "error after reset");
    $display("test reset values done");
    // field decoding and reserved bits
    coupler_model_inst.wr_general(IDX_LIM_EN, 8'hFF);
    rd_check(IDX_LIM_EN, 8'h03);
    coupler_model_inst.wr(IDX_MAINS, 8'hF6);
    rd_check(IDX_MAINS, 8'h06);
    for (int k = 0; k < 3; k++) begin
      coupler_model_inst.wr(IDX_MAINS, {4'h0, k[1:0], k[1:0]});
      @(negedge sys_clk);
      check({12'h0, mains_sel}, {12'h0, k[1:0], k[1:0]}, "mains select");
    end
    coupler_model_inst.wr(IDX_SPARE_A + 4'h4, 8'hAA);
    rd_check(4'h5, 8'h00);
    coupler_model_inst.wr_general(IDX_IRQ_EN, IRQ_ON);
    rd_check(IDX_IRQ_EN, 8'h40);
    $display("test fields done");
    // refusals: general record while running, unknown range code
    coupler_model_inst.wr(IDX_IRQ_EN, IRQ_OFF);
    repeat (2) @(negedge sys_clk);
    check({14'h0, param_err, interrupt_report_enable_irq}, 16'h0003, "running write refused");
    rd_check(IDX_IRQ_EN, 8'h40);
    coupler_model_inst.wr(IDX_LIM_EN, 8'h00);
    rd_check(IDX_LIM_EN, 8'h03);
    check({15'h0, param_err}, 16'h0001, "running limit write refused");
    coupler_model_inst.wr(IDX_CODE[0], CODE_FMT_A);
    repeat (2) @(negedge sys_clk);
    check({14'h0, param_err, interrupt_report_enable_irq}, 16'h0000, "accepted write clears");
    coupler_model_inst.wr(IDX_CODE[0], 8'h33);
    rd_check(IDX_CODE[0], 8'h10);
    check({15'h0, param_err}, 16'h0001, "bad code flagged");
    coupler_model_inst.wr_general(IDX_IRQ_EN, IRQ_OFF);
    coupler_model_inst.wr(IDX_CODE[0], 8'h33);
    repeat (2) @(negedge sys_clk);
    check({14'h0, param_err, interrupt_report_enable_irq}, 16'h0002, "interrupt disabled");
    coupler_model_inst.wr(IDX_CODE[0], CODE_FMT_A);
    $display("test refusals done");
    // both formats side by side, including over and under range
    coupler_model_inst.wr(IDX_CODE[1], CODE_FMT_B);
    for (int i = 0; i < 5; i++) begin
      conv(mv_tab[i], mv_tab[i]);
      check(ch0_value, a_tab[i], "format 10h value");
      check(ch1_value, b_tab[i], "format 20h value");
      check({14'h0, value_valid}, 16'h0003, "both valid");
    end
    coupler_model_inst.wr(IDX_CODE[1], CODE_OFF);
    conv(16'h03E8, 16'h03E8);
    check({14'h0, value_valid}, 16'h0001, "channel off");
    $display("test scaling done");
    // limits: ch0 upper 3000, lower 2000; ch1 left at the disabling defaults
    coupler_model_inst.wr(IDX_CODE[1], CODE_FMT_A);
    coupler_model_inst.wr_general(IDX_LIM_EN, 8'h03);
    coupler_model_inst.wr(IDX_HI[0], 8'h0B);
    coupler_model_inst.wr(IDX_HI[0] + IDX_LOW_BYTE, 8'hB8);
    coupler_model_inst.wr(IDX_LO[0], 8'h07);
    coupler_model_inst.wr(IDX_LO[0] + IDX_LOW_BYTE, 8'hD0);
    conv(16'h05DC, 16'h32C8);
    @(negedge sys_clk);
    check({12'h0, limit_over, limit_under}, 16'h0004, "over event");
    @(negedge sys_clk);
    check({15'h0, proc_irq}, 16'h0001, "process event");
    conv(16'h01F4, 16'hF448);
    @(negedge sys_clk);
    check({12'h0, limit_over, limit_under}, 16'h0001, "under event");
    coupler_model_inst.wr_general(IDX_LIM_EN, 8'h02);
    conv(16'h05DC, 16'h0000);
    @(negedge sys_clk);
    check({12'h0, limit_over, limit_under}, 16'h0000, "ch0 check off");
    // bound 30000 lies beyond the 10h nominal span
    coupler_model_inst.wr(IDX_HI[0], 8'h75);
    coupler_model_inst.wr(IDX_HI[0] + IDX_LOW_BYTE, 8'h30);
    rd_check(IDX_HI[0], 8'h0B);
    rd_check(IDX_HI[0] + IDX_LOW_BYTE, 8'hB8);
    check({15'h0, param_err}, 16'h0001, "bound refused");
    coupler_model_inst.wr(IDX_HI[0], 8'h7F);
    coupler_model_inst.wr(IDX_HI[0] + IDX_LOW_BYTE, 8'hFF);
    @(negedge sys_clk);
    check({15'h0, param_err}, 16'h0000, "disabling bound accepted");
    $display("test limits done");
    end_of_test();
  end
endmodule : dual_input_param_scaling_tb
